// *** pas_core.sv ***
/*
  Program counter, return stack, indirect pointers and the program-memory
  read path of an 8-bit core.
  Assumes the instruction sequencer issues one command per cycle and holds
  off while ind_busy is high; program memory answers in the same cycle
  that pm_addr is presented.
*/
// Notes on behaviour
// - Return stack: 16 entries, 15 bits
// - Overflow and underflow set sticky flags
// - Optional reset on stack error
// - Two independent 16-bit indirect pointers
// - Pointers reach data and program memory
// - Program-memory indirect access adds one cycle
// - Linear view of general-purpose RAM
// - Program counter 15 bits, 32K words
// - Addresses above 07FFh wrap around
// - Reset vector 0000h, interrupt vector 0004h
// - Context shadowed on interrupt, restored on return
// - 128-byte high-endurance flash window
// - High endurance: low byte, 0780h-07FFh
// - Core executes 49 instructions
// - Pointer bit 15 selects program memory
// - Program read returns low eight bits
// - Indirect writes never touch program memory
`default_nettype none
module pas_core
  import pas_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire pas_cmd_type        cmd,
  input  wire logic [PC_W-1:0]    target,
  input  wire logic [CTX_W-1:0]   ctx_in,
  input  wire logic               stk_rst_en,
  input  wire logic               ovf_clr,
  input  wire logic               unf_clr,
  input  wire logic               fsr_wr,
  input  wire logic               fsr_sel,
  input  wire logic               fsr_hi,
  input  wire logic [7:0]         fsr_wbyte,
  input  wire logic               ind_rd,
  input  wire logic               ind_wr,
  input  wire logic               ind_sel,
  input  wire logic [7:0]         ind_wdata,
  input  wire logic [PM_W-1:0]    pm_rdata,
  output logic [PC_W-1:0]         fetch_addr,
  output logic                    stack_overflow_flag,
  output logic                    stack_underflow_flag,
  output logic                    sw_reset,
  output logic [FSR_W-1:0]        fsr0,
  output logic [FSR_W-1:0]        fsr1,
  output logic [CTX_W-1:0]        ctx_out,
  output logic                    ctx_restore,
  output logic [PC_W-1:0]         pm_addr,
  output logic                    ind_busy,
  output logic [7:0]              ind_rdata,
  output logic                    ind_valid,
  output logic                    hef_hit,
  output logic [DADDR_W-1:0]      data_addr,
  output logic                    data_rd,
  output logic                    data_wr,
  output logic [7:0]              data_wdata
);
  typedef enum logic {PAS_IDLE, PAS_PM_WAIT} pas_state_type;

  // Opcode space must leave room for the full instruction set
  localparam int OPS_NEEDED = INSTR_COUNT;

  logic [PC_W-1:0]    pc_q,  pc_d;
  logic [PC_W-1:0]    fa_q,  fa_d;
  logic               ovf_q, ovf_d;
  logic               unf_q, unf_d;
  logic               swr_q, swr_d;
  logic [FSR_W-1:0]   f0_q,  f0_d;
  logic [FSR_W-1:0]   f1_q,  f1_d;
  logic [FSR_W-1:0]   sf0_q, sf0_d;
  logic [FSR_W-1:0]   sf1_q, sf1_d;
  logic [CTX_W-1:0]   ctx_q, ctx_d;
  logic               rst_q, rst_d;
  pas_state_type      st_q,  st_d;
  logic [PC_W-1:0]    pma_q, pma_d;
  logic               bsy_q, bsy_d;
  logic [7:0]         rd_q,  rd_d;
  logic               vld_q, vld_d;
  logic               hef_q, hef_d;
  logic [DADDR_W-1:0] da_q,  da_d;
  logic               drd_q, drd_d;
  logic               dwr_q, dwr_d;
  logic [7:0]         dwd_q, dwd_d;

  logic               push, pop, ovf_ev, unf_ev;
  logic [PC_W-1:0]    push_data, stk_top;
  logic [FSR_W-1:0]   ptr;

  // ****************************************
  // Helpers
  // ****************************************
  // Only 2K words exist; upper address bits are simply dropped
  function automatic logic [PC_W-1:0] wrap(input logic [PC_W-1:0] a);
    return a & PM_LAST;
  endfunction

  // Linear window folds 80-byte GPR slices of banks 0-30 and a 64-byte slice of bank 31 together
  function automatic logic [DADDR_W-1:0] dmap(input logic [FSR_W-1:0] p);
    logic [FSR_W-1:0] off;
    logic [FSR_W-1:0] bnk;
    logic [FSR_W-1:0] low;
    off = p - LIN_BASE;
    bnk = off / GPR_PER_BNK;
    low = off % GPR_PER_BNK + GPR_OFFSET;
    if (p >= LIN_BASE && p <= LIN_LAST) begin
      return {bnk[4:0], low[6:0]};
    end
    return p[DADDR_W-1:0];
  endfunction

  // ****************************************
  // Return stack
  // ****************************************
  pas_stack pas_stack_i (
    .clk       (clk),
    .arst_n    (arst_n),
    .push      (push),
    .pop       (pop),
    .push_data (push_data),
    .top       (stk_top),
    .overflow  (ovf_ev),
    .underflow (unf_ev)
  );

  // ****************************************
  // Program counter and flags
  // ****************************************
  always_comb begin
    push      = 1'b0;
    pop       = 1'b0;
    push_data = pc_q + 15'h1;
    pc_d      = pc_q;
    ctx_d     = ctx_q;
    sf0_d     = sf0_q;
    sf1_d     = sf1_q;
    rst_d     = 1'b0;
    unique case (cmd)
      PAS_STEP: begin
        pc_d = pc_q + 15'h1;
      end
      PAS_JUMP: begin
        pc_d = target;
      end
      PAS_CALL: begin
        push = 1'b1;
        pc_d = target;
      end
      PAS_RET: begin
        pop  = 1'b1;
        pc_d = stk_top;
      end
      PAS_IRQ: begin
        push      = 1'b1;
        push_data = pc_q;
        pc_d      = IRQ_VEC;
        ctx_d     = ctx_in;
        sf0_d     = f0_q;
        sf1_d     = f1_q;
      end
      PAS_RETFIE: begin
        pop   = 1'b1;
        pc_d  = stk_top;
        rst_d = 1'b1;
      end
      default: begin
      end
    endcase
    fa_d  = wrap(pc_d);
    // A new event wins over a clear in the same cycle
    ovf_d = ovf_ev || (ovf_q && !ovf_clr);
    unf_d = unf_ev || (unf_q && !unf_clr);
    swr_d = stk_rst_en && (ovf_ev || unf_ev);
  end

  // ****************************************
  // Pointers and indirect access
  // ****************************************
  always_comb begin
    f0_d  = f0_q;
    f1_d  = f1_q;
    st_d  = st_q;
    pma_d = pma_q;
    bsy_d = 1'b0;
    rd_d  = rd_q;
    vld_d = 1'b0;
    hef_d = 1'b0;
    da_d  = da_q;
    drd_d = 1'b0;
    dwr_d = 1'b0;
    dwd_d = dwd_q;
    ptr   = ind_sel ? f1_q : f0_q;
    if (rst_q) begin
      f0_d = sf0_q;
      f1_d = sf1_q;
    end else if (fsr_wr) begin
      if (fsr_sel) begin
        if (fsr_hi) f1_d[15:8] = fsr_wbyte;
        else        f1_d[7:0]  = fsr_wbyte;
      end else begin
        if (fsr_hi) f0_d[15:8] = fsr_wbyte;
        else        f0_d[7:0]  = fsr_wbyte;
      end
    end
    unique case (st_q)
      PAS_IDLE: begin
        if (ind_rd && ptr[FSR_PM_BIT]) begin
          pma_d = wrap(ptr[PC_W-1:0]);
          bsy_d = 1'b1;
          st_d  = PAS_PM_WAIT;
        end else if (ind_rd) begin
          da_d  = dmap(ptr);
          drd_d = 1'b1;
        end else if (ind_wr && !ptr[FSR_PM_BIT]) begin
          da_d  = dmap(ptr);
          dwr_d = 1'b1;
          dwd_d = ind_wdata;
        end
      end
      PAS_PM_WAIT: begin
        rd_d  = pm_rdata[7:0];
        vld_d = 1'b1;
        // Only the low byte of the top 128 words is high endurance
        hef_d = (pma_q >= HEF_FIRST);
        st_d  = PAS_IDLE;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_q  <= RESET_VEC;
      fa_q  <= RESET_VEC;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      swr_q <= 1'b0;
      ctx_q <= '0;
      sf0_q <= FSR_RST;
      sf1_q <= FSR_RST;
      rst_q <= 1'b0;
      f0_q  <= FSR_RST;
      f1_q  <= FSR_RST;
      st_q  <= PAS_IDLE;
      pma_q <= RESET_VEC;
      bsy_q <= 1'b0;
      rd_q  <= 8'h00;
      vld_q <= 1'b0;
      hef_q <= 1'b0;
      da_q  <= '0;
      drd_q <= 1'b0;
      dwr_q <= 1'b0;
      dwd_q <= 8'h00;
    end else begin
      pc_q  <= pc_d;
      fa_q  <= fa_d;
      ovf_q <= ovf_d;
      unf_q <= unf_d;
      swr_q <= swr_d;
      ctx_q <= ctx_d;
      sf0_q <= sf0_d;
      sf1_q <= sf1_d;
      rst_q <= rst_d;
      f0_q  <= f0_d;
      f1_q  <= f1_d;
      st_q  <= st_d;
      pma_q <= pma_d;
      bsy_q <= bsy_d;
      rd_q  <= rd_d;
      vld_q <= vld_d;
      hef_q <= hef_d;
      da_q  <= da_d;
      drd_q <= drd_d;
      dwr_q <= dwr_d;
      dwd_q <= dwd_d;
    end
  end

  assign fetch_addr           = fa_q;
  assign stack_overflow_flag  = ovf_q;
  assign stack_underflow_flag = unf_q;
  assign sw_reset             = swr_q;
  assign fsr0                 = f0_q;
  assign fsr1                 = f1_q;
  assign ctx_out              = ctx_q;
  assign ctx_restore          = rst_q;
  assign pm_addr              = pma_q;
  assign ind_busy             = bsy_q;
  assign ind_rdata            = rd_q;
  assign ind_valid            = vld_q;
  assign hef_hit              = hef_q;
  assign data_addr            = da_q;
  assign data_rd              = drd_q;
  assign data_wr              = dwr_q;
  assign data_wdata           = dwd_q;
endmodule
`default_nettype wire

// *** pas_pkg.sv ***
/*
  Constants and command types for the program addressing and stack block.
  Assumes one core clock domain; no software-visible register map.
*/
`default_nettype none
package pas_pkg;
  localparam int          PC_W        = 15;
  localparam int          STK_DEPTH   = 16;
  localparam int          STK_PTR_W   = 5;
  localparam int          FSR_W       = 16;
  localparam int          PM_W        = 14;
  localparam int          DADDR_W     = 12;
  localparam int          CTX_W       = 32;
  localparam int          INSTR_COUNT = 49;
  localparam logic [14:0] RESET_VEC   = 15'h0000;
  localparam logic [14:0] IRQ_VEC     = 15'h0004;
  localparam logic [14:0] PM_LAST     = 15'h07FF;
  localparam logic [14:0] HEF_FIRST   = 15'h0780;
  localparam int          HEF_BYTES   = 128;
  localparam int          FSR_PM_BIT  = 15;
  localparam logic [15:0] LIN_BASE    = 16'h2000;
  localparam logic [15:0] LIN_LAST    = 16'h29EF;
  localparam logic [15:0] GPR_PER_BNK = 16'h0050;
  localparam logic [15:0] GPR_OFFSET  = 16'h0020;
  localparam logic [15:0] FSR_RST     = 16'h0000;
  localparam logic [4:0]  PTR_RST     = 5'h00;

  typedef enum logic [2:0] {
    PAS_NONE, PAS_STEP, PAS_JUMP, PAS_CALL, PAS_RET, PAS_IRQ, PAS_RETFIE
  } pas_cmd_type;
endpackage
`default_nettype wire

// *** pas_stack.sv ***
/*
  Return-address stack: 16 entries of 15 bits held in flip-flops.
  Assumes push and pop are never asked in the same cycle.
*/
`default_nettype none
module pas_stack
  import pas_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic            push,
  input  wire logic            pop,
  input  wire logic [PC_W-1:0] push_data,
  output var  logic [PC_W-1:0] top,
  output var  logic            overflow,
  output var  logic            underflow
);
  logic [PC_W-1:0]      mem_q [STK_DEPTH];
  logic [PC_W-1:0]      mem_d [STK_DEPTH];
  logic [STK_PTR_W-1:0] cnt_q;
  logic [STK_PTR_W-1:0] cnt_d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    cnt_d     = cnt_q;
    overflow  = push && (cnt_q == STK_PTR_W'(STK_DEPTH));
    underflow = pop && (cnt_q == '0);
    // Full pushes are dropped so the older return addresses survive
    if (push && !overflow) begin
      cnt_d = cnt_q + 5'h1;
    end else if (pop && !underflow) begin
      cnt_d = cnt_q - 5'h1;
    end
    top = (cnt_q == '0) ? RESET_VEC : mem_q[4'(cnt_q - 5'h1)];
  end

  for (genvar i = 0; i < STK_DEPTH; i++) begin : g_ent
    always_comb begin
      mem_d[i] = mem_q[i];
      if (push && !overflow && (cnt_q == STK_PTR_W'(i))) begin
        mem_d[i] = push_data;
      end
    end
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        mem_q[i] <= RESET_VEC;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= PTR_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// *** pas_core_sva.sv ***
/* Checker for pas_core: program counter, stack, pointers, indirect path.
   Assumes one clock domain; bound to every pas_core instance. */
`default_nettype none
module pas_core_chk
  import pas_pkg::*;
(
  input wire logic             clk,
  input wire logic             arst_n,
  input wire pas_cmd_type      cmd,
  input wire logic [PC_W-1:0]  target,
  input wire logic [CTX_W-1:0] ctx_in,
  input wire logic             stk_rst_en,
  input wire logic             ovf_clr,
  input wire logic             fsr_wr,
  input wire logic             fsr_sel,
  input wire logic             fsr_hi,
  input wire logic [7:0]       fsr_wbyte,
  input wire logic             ind_rd,
  input wire logic             ind_wr,
  input wire logic             ind_sel,
  input wire logic [PM_W-1:0]  pm_rdata,
  input wire logic [PC_W-1:0]  fetch_addr,
  input wire logic             stack_overflow_flag,
  input wire logic             stack_underflow_flag,
  input wire logic             sw_reset,
  input wire logic [FSR_W-1:0] fsr0,
  input wire logic [FSR_W-1:0] fsr1,
  input wire logic [CTX_W-1:0] ctx_out,
  input wire logic             ctx_restore,
  input wire logic [PC_W-1:0]  pm_addr,
  input wire logic             ind_busy,
  input wire logic [7:0]       ind_rdata,
  input wire logic             ind_valid,
  input wire logic             hef_hit,
  input wire logic             data_rd,
  input wire logic             data_wr
);
  // ********************************
  // Helper logic
  // ********************************
  logic [4:0] depth_q, depth_d;
  logic [1:0] wsel_q, wsel_d;
  logic       push, pop, full_push, empty_pop, ptr_pm, hef_now;
  logic [7:0] pm_lo, fsr_byte;
  assign push = cmd == PAS_CALL || cmd == PAS_IRQ;
  assign pop = cmd == PAS_RET || cmd == PAS_RETFIE;
  assign full_push = push && depth_q == 5'h10;
  assign empty_pop = pop && depth_q == 5'h00;
  assign ptr_pm = ind_sel ? fsr1[FSR_PM_BIT] : fsr0[FSR_PM_BIT];
  // Wrap-aware, so an unwrapped pm_addr still hits the window
  assign hef_now = pm_addr[10:0] >= HEF_FIRST[10:0];
  assign pm_lo = pm_rdata[7:0];
  assign fsr_byte = wsel_q[1] ? (wsel_q[0] ? fsr1[15:8] : fsr1[7:0])
                              : (wsel_q[0] ? fsr0[15:8] : fsr0[7:0]);
  // A dropped push or empty pop leaves the occupancy alone
  always_comb begin
    depth_d = depth_q;
    wsel_d = {fsr_sel, fsr_hi};
    if (push && !full_push) depth_d = depth_q + 5'h01;
    if (pop && !empty_pop) depth_d = depth_q - 5'h01;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      depth_q <= 5'h00;
      wsel_q <= 2'h0;
    end else begin
      depth_q <= depth_d;
      wsel_q <= wsel_d;
    end
  end
  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence prog_req_s;
    ind_rd && ptr_pm && !ind_busy;
  endsequence
  sequence prog_done_s;
    ind_valid && ind_rdata == $past(pm_lo) && hef_hit == $past(hef_now);
  endsequence
  jump_wrap_a: assert property (
    cmd inside {PAS_JUMP, PAS_CALL} |=>
      fetch_addr == ($past(target) & PM_LAST))
    else $error("jump target not wrapped");
  irq_vector_a: assert property (
    cmd == PAS_IRQ |=> fetch_addr == IRQ_VEC && ctx_out == $past(ctx_in))
    else $error("interrupt entry wrong");
  ovf_full_a: assert property (
    full_push |=> stack_overflow_flag)
    else $error("overflow not flagged");
  unf_empty_a: assert property (
    empty_pop |=> stack_underflow_flag && fetch_addr == RESET_VEC)
    else $error("underflow not flagged");
  ovf_sticky_a: assert property (
    stack_overflow_flag && !ovf_clr |=> stack_overflow_flag)
    else $error("overflow flag lost");
  err_reset_a: assert property (
    (full_push || empty_pop) && stk_rst_en |=> sw_reset)
    else $error("stack error reset missing");
  fsr_write_a: assert property (
    fsr_wr && !ctx_restore |=> fsr_byte == $past(fsr_wbyte))
    else $error("pointer byte not written");
  prog_read_a: assert property (
    prog_req_s |=> ind_busy && !ind_valid ##1 prog_done_s)
    else $error("program read wrong");
  data_read_a: assert property (
    ind_rd && !ptr_pm && !ind_busy |=> data_rd && !ind_busy)
    else $error("data read missing");
  pm_write_a: assert property (
    ind_wr && !ind_rd && ptr_pm && !ind_busy |=> !data_wr && !ind_busy)
    else $error("program write had effect");
endmodule
bind pas_core pas_core_chk pas_core_chk_i (.clk, .arst_n, .cmd, .target,
  .ctx_in, .stk_rst_en, .ovf_clr, .fsr_wr, .fsr_sel, .fsr_hi, .fsr_wbyte,
  .ind_rd, .ind_wr, .ind_sel, .pm_rdata, .fetch_addr, .stack_overflow_flag,
  .stack_underflow_flag, .sw_reset, .fsr0, .fsr1, .ctx_out, .ctx_restore,
  .pm_addr, .ind_busy, .ind_rdata, .ind_valid, .hef_hit, .data_rd,
  .data_wr);
`default_nettype wire

// *** pas_core_tb.sv ***
/* Self-checking bench for pas_core with random and corner stimulus.
   Assumes the checker is bound by its own file. */
`default_nettype none
module pas_core_tb
  import pas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, stk_rst_en, ovf_clr, unf_clr, fsr_wr, fsr_sel, fsr_hi;
  logic ind_rd, ind_wr, ind_sel, stack_overflow_flag, stack_underflow_flag;
  logic sw_reset, ctx_restore, ind_busy, ind_valid, hef_hit, data_rd, data_wr;
  pas_cmd_type cmd;
  logic [PC_W-1:0] target, fetch_addr, pm_addr, t, pc;
  logic [PC_W-1:0] stk[$];
  logic [CTX_W-1:0] ctx_in, ctx_out, cx;
  logic [7:0] fsr_wbyte, ind_wdata, ind_rdata, data_wdata;
  logic [PM_W-1:0] pm_rdata, pmv;
  logic [FSR_W-1:0] fsr0, fsr1, off;
  logic [DADDR_W-1:0] data_addr;
  logic [1:0] clr;
  logic [7:0] wd;
  logic en;
  int num_errors, samples_checked, cyc, r;
  pas_core pas_core_i (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask
  // One command per two cycles, sampled just after the edge that takes it
  task automatic go(input pas_cmd_type c, input logic [PC_W-1:0] tg);
    @(posedge clk);
    cmd <= c;
    {target, ctx_in, stk_rst_en} <= {tg, cx, en};
    {ovf_clr, unf_clr} <= clr;
    @(posedge clk);
    cmd <= PAS_NONE;
    {ovf_clr, unf_clr} <= 2'b00;
    #1;
  endtask
  task automatic setp(input logic s, input logic [15:0] v);
    for (int h = 0; h < 2; h++) begin
      @(posedge clk);
      {fsr_wr, fsr_sel, fsr_hi, fsr_wbyte} <= {1'b1, s, h[0], v[h*8+:8]};
      @(posedge clk);
      fsr_wr <= 1'b0;
    end
    #1 chk_v(s ? fsr1 : fsr0, v);
  endtask
  task automatic acc(input logic rd, input logic wr, input logic s);
    @(posedge clk);
    {ind_rd, ind_wr, ind_sel, ind_wdata} <= {rd, wr, s, wd};
    @(posedge clk);
    {ind_rd, ind_wr, pm_rdata} <= {2'b00, pmv};
    #1;
  endtask
  function automatic logic [11:0] lin(input logic [15:0] o);
    return 12'((o / 16'h0050) * 16'h0080 + 16'h0020 + o % 16'h0050);
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    {arst_n, stk_rst_en, ovf_clr, unf_clr, fsr_wr, fsr_sel, fsr_hi} = '0;
    {ind_rd, ind_wr, ind_sel, target, ctx_in, fsr_wbyte} = '0;
    {ind_wdata, pm_rdata, cx, clr, en, pmv, wd} = '0;
    cmd = PAS_NONE;
    r = $urandom(32'h499a_a708);
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    #1 chk_v(fetch_addr, RESET_VEC);
    chk_f(stack_overflow_flag | stack_underflow_flag, 1'b0);
    for (int i = 0; i < 8; i++) begin
      t = i == 0 ? 15'h7fff : PC_W'($urandom);
      go(PAS_JUMP, t);
      chk_v(fetch_addr, t & PM_LAST);
    end
    go(PAS_STEP, 15'h0000);
    chk_v(fetch_addr, (t + 15'h0001) & PM_LAST);
    go(PAS_JUMP, 15'h0123);
    cx = $urandom;
    go(PAS_IRQ, 15'h0000);
    chk_v(fetch_addr, IRQ_VEC);
    chk_v(ctx_out, cx);
    go(PAS_RETFIE, 15'h0000);
    chk_v(fetch_addr, 15'h0123);
    chk_f(ctx_restore, 1'b1);
    $display("test vectors done");
    pc = 15'h0123;
    en = 1'b1;
    for (int i = 0; i <= 16; i++) begin
      t = PC_W'($urandom) & 15'h03ff;
      go(PAS_CALL, t);
      if (i < 16) stk.push_back(pc + 15'h0001);
      pc = t;
      chk_v(fetch_addr, t);
      chk_f(stack_overflow_flag, i == 16);
      chk_f(sw_reset, i == 16);
    end
    clr = 2'b10;
    go(PAS_NONE, 15'h0000);
    clr = 2'b00;
    chk_f(stack_overflow_flag, 1'b0);
    while (stk.size() > 0) begin
      go(PAS_RET, 15'h0000);
      chk_v(fetch_addr, stk.pop_back());
      chk_f(stack_underflow_flag, 1'b0);
    end
    en = 1'b0;
    go(PAS_RET, 15'h0000);
    chk_v(fetch_addr, RESET_VEC);
    chk_f(stack_underflow_flag, 1'b1);
    chk_f(sw_reset, 1'b0);
    clr = 2'b01;
    go(PAS_NONE, 15'h0000);
    clr = 2'b00;
    chk_f(stack_underflow_flag, 1'b0);
    // Empty pop and clear in one cycle: the new event must win
    en = 1'b1;
    clr = 2'b01;
    go(PAS_RETFIE, 15'h0000);
    clr = 2'b00;
    chk_f(stack_underflow_flag, 1'b1);
    chk_f(sw_reset, 1'b1);
    chk_v(fetch_addr, RESET_VEC);
    en = 1'b0;
    $display("test stack done");
    for (int k = 0; k < 4; k++) begin
      off = k == 0 ? 16'h0000 : k == 1 ? 16'h09ef : 16'($urandom % 2544);
      setp(k[0], LIN_BASE + off);
      acc(1'b1, 1'b0, k[0]);
      chk_f(data_rd, 1'b1);
      chk_v(data_addr, lin(off));
      wd = 8'($urandom);
      acc(1'b0, 1'b1, k[0]);
      chk_f(data_wr, 1'b1);
      chk_v(data_addr, lin(off));
      chk_v(data_wdata, wd);
    end
    setp(1'b1, 16'h8780);
    acc(1'b0, 1'b1, 1'b1);
    chk_f(data_wr, 1'b0);
    for (int k = 0; k < 5; k++) begin
      t = k == 0 ? 15'h077f : k == 1 ? 15'h0780 : k == 2 ? 15'h07ff
          : PC_W'($urandom) & PM_LAST;
      pmv = PM_W'($urandom);
      setp(k[0], {1'b1, t});
      acc(1'b1, 1'b0, k[0]);
      chk_f(ind_busy & ~ind_valid & ~data_rd, 1'b1);
      chk_v(pm_addr, t);
      @(posedge clk);
      #1 chk_f(ind_valid, 1'b1);
      chk_v(ind_rdata, pmv[7:0]);
      chk_f(hef_hit, t >= HEF_FIRST);
    end
    $display("test indirect done");
    final_report();
  end
endmodule
`default_nettype wire
